/* hdl/rgb_dim_pkg.sv */
// Shared constants and types for the three-channel LED dimming controller
package rgb_dim_pkg;

  // Clock and ramp timebase
  localparam int CLK_PERIOD_NS = 8;
  localparam int STEP_UNIT_MS = 8;
  localparam int STEP_UNIT_NS = STEP_UNIT_MS * 1000000;
  localparam int STEP_UNIT_CYCLES = STEP_UNIT_NS / CLK_PERIOD_NS;

  // Duty modulator slot rate: one slot every PWM_TICK_CYCLES core clocks
  localparam int PWM_TICK_CYCLES = 16;
  localparam logic [3:0] PWM_TICK_LAST = 4'(PWM_TICK_CYCLES - 1);

  // Bus target address (7 bits) and write direction
  localparam logic [6:0] DEV_ADDR = 7'h38;
  localparam logic DIR_WRITE = 1'b0;

  // Byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

  // Field values
  localparam logic [4:0] STEP_ZERO = 5'h00;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam logic [4:0] DUTY_OFF = 5'h00;
  localparam logic [4:0] DUTY_FULL = 5'h1F;
  localparam logic [4:0] PWM_SLOT_LAST = 5'h1E;
  localparam logic [31:0] TIMER_ZERO = 32'h0000_0000;
  localparam logic [31:0] TIMER_ONE = 32'h0000_0001;

  // Command selector in bits 7:5 of the command byte
  typedef enum logic [2:0] {
    CMD_SHUTDOWN = 3'b000,
    CMD_PEAK = 3'b001,
    CMD_DUTY1 = 3'b010,
    CMD_DUTY2 = 3'b011,
    CMD_DUTY3 = 3'b100,
    CMD_RISE_TGT = 3'b101,
    CMD_FALL_TGT = 3'b110,
    CMD_RAMP_RUN = 3'b111
  } cmd_t;

  // Bus receiver states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ACK_ADDR = 3'b010,
    BUS_DATA = 3'b011,
    BUS_ACK_DATA = 3'b100,
    BUS_IGNORE = 3'b101
  } bus_state_t;

endpackage : rgb_dim_pkg

/* hdl/duty_modulator.sv */
// One 32-level on/off duty modulator for a single LED output
`timescale 1ns/1ps
module duty_modulator (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input wire logic [4:0] duty_in,
  input wire logic gate_in,
  output logic led_on_out
);
  import rgb_dim_pkg::*;

  typedef struct packed {
    logic [4:0] slot;
    logic on;
  } mod_state_t;

  mod_state_t q;
  mod_state_t d;

  // Slot counter runs 0..30; on while slot below duty, full duty is always on
  always_comb begin
    d = q;
    if (tick_in) begin
      d.slot = (q.slot == PWM_SLOT_LAST) ? STEP_ZERO : q.slot + STEP_ONE;
    end
    d.on = gate_in && (duty_in != DUTY_OFF) && ((duty_in == DUTY_FULL) || (q.slot < duty_in));
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign led_on_out = q.on;

endmodule : duty_modulator

/* hdl/rgb_dim_ctrl.sv */
// Command receiver, peak current ramp engine and duty modulators for three LEDs
`timescale 1ns/1ps
//
// Behaviour
// - Write-only bus target; address then one command byte, bits 7:5 select function.
// - Selector zero shuts down, current step forced to zero, low bits ignored.
// - Selector one loads low five bits into shared peak current step.
// - Peak step write with no ramp running takes effect at acknowledge.
// - Selectors two to four load duty of outputs one, two, three.
// - Selectors five and six load rising and falling target step positions.
// - Selector seven stores step time and starts a gradual ramp at once.
// - Step time field weighs 8 ms per unit.
// - Step count is present-to-target distance; duration is count times step time.
// - Ramp moves one step position per step period from start to end.
// - Step never leaves 0..31; bad commands leave a controlled state.
// - Rising past target wraps via maximum to zero; falling mirrors this.
// - A brightness change begins when the data byte is acknowledged.
// - Each parameter register has its own transfer and may be preloaded.
// - Five-bit step limits one ramp to at most 31 positions.
// - Step zero forces LED current to zero; thirty and thirty-one equal current.
// - Each duty modulator uses a five-bit, 32-level value.
// - Duty zero is off, all ones is always on, others proportional.
// - Duty writable any time, gates ratio only, untouched by ramps.
// - Peak step applies to all three outputs; duties differ per LED.
module rgb_dim_ctrl #(
  parameter int STEP_UNIT_CYCLES_P = rgb_dim_pkg::STEP_UNIT_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [4:0] current_step_out,
  output logic [4:0] ramp_steps_left_out,
  output logic ramp_busy_out,
  output logic [2:0] led_on_out
);
  import rgb_dim_pkg::*;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    bus_state_t bus;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic sda_oe;
    logic sda_o;
    logic [4:0] peak_current_step;
    logic [4:0] led1_duty;
    logic [4:0] led2_duty;
    logic [4:0] led3_duty;
    logic [4:0] ramp_target;
    logic dir_up;
    logic [4:0] ramp_step_time;
    logic ramp_busy;
    logic [4:0] steps_left;
    logic [31:0] timer;
    logic [3:0] tick_div;
    logic tick;
  } ctrl_state_t;

  // Address byte as received: target address then direction bit
  typedef struct packed {
    logic [6:0] addr;
    logic rw;
  } addr_byte_t;

  // Command byte as received: function selector then five-bit value
  typedef struct packed {
    cmd_t sel;
    logic [4:0] val;
  } cmd_byte_t;

  ctrl_state_t q;
  ctrl_state_t d;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic cmd_go;
  logic [31:0] step_reload;
  logic [2:0] duty_on;
  logic [4:0] duty_vec [3];
  addr_byte_t addr_byte;
  cmd_byte_t cmd_byte;
  logic addr_match;
  logic [4:0] step_up;
  logic [4:0] step_down;
  logic [4:0] dist_up;
  logic [4:0] dist_down;
  logic [31:0] start_reload;
  logic ramp_at_target;
  logic step_due;

  // Line events seen on the synchronised copies only
  assign scl_rise = q.scl_s2 & ~q.scl_d;
  assign scl_fall = ~q.scl_s2 & q.scl_d;
  assign bus_start = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
  assign bus_stop = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;

  // Step period in core clocks: field times unit, no division needed
  assign step_reload = 32'(q.ramp_step_time) * 32'(STEP_UNIT_CYCLES_P);

  // Byte views of the receive shifter; only one view is meaningful per state
  assign addr_byte = addr_byte_t'(q.shift);
  assign cmd_byte = cmd_byte_t'(q.shift);
  assign addr_match = (addr_byte.addr == DEV_ADDR) && (addr_byte.rw == DIR_WRITE);

  // Neighbouring step positions; 5-bit arithmetic wraps between 31 and 0
  assign step_up = q.peak_current_step + STEP_ONE;
  assign step_down = q.peak_current_step - STEP_ONE;

  // Ramp length per direction, modulo 32 so that a wrap is counted too
  assign dist_up = q.ramp_target - q.peak_current_step;
  assign dist_down = q.peak_current_step - q.ramp_target;

  // Ramp status: target reached, or the step timer has run down
  assign ramp_at_target = (q.peak_current_step == q.ramp_target);
  assign step_due = (q.timer <= TIMER_ONE);

  // First step period of a new ramp, from the field just received
  assign start_reload = 32'(cmd_byte.val) * 32'(STEP_UNIT_CYCLES_P);

  // Next-state logic for receiver, registers and ramp engine
  always_comb begin
    d = q;
    cmd_go = 1'b0;
    d.sda_o = 1'b0;

    // Two-stage synchronisers, then one delay stage for edge detection
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_d = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_d = q.sda_s2;

    // Slot enable for the duty modulators
    d.tick = (q.tick_div == PWM_TICK_LAST);
    d.tick_div = d.tick ? 4'h0 : q.tick_div + 4'h1;

    // Receiver: address byte, then one command byte
    unique case (q.bus)
      BUS_IDLE, BUS_IGNORE: begin
      end
      // Shift in eight bits on rising bus clock edges, answer after the eighth
      BUS_ADDR, BUS_DATA: begin
        if (scl_rise && (q.bit_cnt != BITS_PER_BYTE)) begin
          d.shift = {q.shift[6:0], q.sda_s2};
          d.bit_cnt = q.bit_cnt + 4'h1;
        end else if (scl_fall && (q.bit_cnt == BITS_PER_BYTE)) begin
          if (q.bus == BUS_DATA) begin
            d.sda_oe = 1'b1;
            d.bus = BUS_ACK_DATA;
            cmd_go = 1'b1;
          end else if (addr_match) begin
            d.sda_oe = 1'b1;
            d.bus = BUS_ACK_ADDR;
          end else begin
            d.bus = BUS_IGNORE;
          end
        end
      end
      // Release the line after the ninth clock, then take the command byte
      BUS_ACK_ADDR: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.bit_cnt = BIT_CNT_ZERO;
          d.bus = BUS_DATA;
        end
      end
      // Only one command byte per frame; later bytes get no acknowledge
      BUS_ACK_DATA: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.bus = BUS_IGNORE;
        end
      end
      default: begin
        d.bus = BUS_IDLE;
        d.sda_oe = 1'b0;
      end
    endcase

    // Start and stop conditions override the byte engine
    if (bus_start) begin
      d.bus = BUS_ADDR;
      d.bit_cnt = BIT_CNT_ZERO;
      d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      d.bus = BUS_IDLE;
      d.sda_oe = 1'b0;
    end

    // Ramp engine: one step per period, wrap through 5-bit arithmetic
    if (q.ramp_busy) begin
      if (ramp_at_target) begin
        d.ramp_busy = 1'b0;
        d.steps_left = STEP_ZERO;
      end else if (!step_due) begin
        d.timer = q.timer - TIMER_ONE;
      end else begin
        d.peak_current_step = q.dir_up ? step_up : step_down;
        d.steps_left = q.steps_left - STEP_ONE;
        d.timer = step_reload;
      end
    end

    // Command byte decode; a new command takes priority over a ramp step
    if (cmd_go) begin
      unique case (cmd_byte.sel)
        CMD_SHUTDOWN: begin
          d.peak_current_step = STEP_ZERO;
          d.ramp_busy = 1'b0;
          d.steps_left = STEP_ZERO;
        end
        // A direct write also ends a running ramp, leaving a known step
        CMD_PEAK: begin
          d.peak_current_step = cmd_byte.val;
          d.ramp_busy = 1'b0;
          d.steps_left = STEP_ZERO;
        end
        CMD_DUTY1: begin
          d.led1_duty = cmd_byte.val;
        end
        CMD_DUTY2: begin
          d.led2_duty = cmd_byte.val;
        end
        CMD_DUTY3: begin
          d.led3_duty = cmd_byte.val;
        end
        CMD_RISE_TGT: begin
          d.ramp_target = cmd_byte.val;
          d.dir_up = 1'b1;
        end
        CMD_FALL_TGT: begin
          d.ramp_target = cmd_byte.val;
          d.dir_up = 1'b0;
        end
        // A start with the target already reached runs no ramp
        CMD_RAMP_RUN: begin
          d.ramp_step_time = cmd_byte.val;
          d.timer = start_reload;
          d.ramp_busy = !ramp_at_target;
          d.steps_left = q.dir_up ? dist_up : dist_down;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.bus <= BUS_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_d <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_d <= 1'b1;
      q.dir_up <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Duty values collected for the per-LED modulators
  assign duty_vec[0] = q.led1_duty;
  assign duty_vec[1] = q.led2_duty;
  assign duty_vec[2] = q.led3_duty;

  // One modulator per LED, all gated by the shared peak step
  for (genvar i = 0; i < 3; i++) begin : g_led
    duty_modulator u_mod (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .tick_in(q.tick),
      .duty_in(duty_vec[i]),
      .gate_in(q.peak_current_step != STEP_ZERO),
      .led_on_out(duty_on[i])
    );
  end

  // Outputs straight from flops
  assign sda_out = q.sda_o;
  assign sda_oe_out = q.sda_oe;
  assign current_step_out = q.peak_current_step;
  assign ramp_steps_left_out = q.steps_left;
  assign ramp_busy_out = q.ramp_busy;
  assign led_on_out = duty_on;

endmodule : rgb_dim_ctrl

/* dv/rgb_dim_ctrl_props.sv */
// Port-level assertions for the LED dimming controller
`timescale 1ns/1ps
module rgb_dim_ctrl_props (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [4:0] current_step_out,
  input wire logic [4:0] ramp_steps_left_out,
  input wire logic ramp_busy_out,
  input wire logic [2:0] led_on_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Acknowledge pulls low, begins only while clock is low, and is short
  AST_SDA_ZERO: assert property (sda_oe_out |-> !sda_out) else $error("sda drive not low");
  AST_ACK_LOW: assert property ($rose(sda_oe_out) |-> !scl_in) else $error("ack in clock high");
  AST_ACK_END: assert property ($rose(sda_oe_out) |-> ##[1:100] !sda_oe_out) else $error("ack stuck");
  // Ramp bookkeeping
  AST_IDLE_LEFT: assert property (!ramp_busy_out |-> ramp_steps_left_out == 5'h00) else $error("left");
  AST_END_TGT: assert property (ramp_busy_out && ramp_steps_left_out == 5'h00 |=> !ramp_busy_out)
    else $error("ramp not ended");
  AST_ONE_STEP: assert property (ramp_busy_out && $past(ramp_busy_out) && $changed(current_step_out)
    |-> 5'(current_step_out - $past(current_step_out)) inside {5'h01, 5'h1F}) else $error("jump");
  AST_LEFT_DEC: assert property (ramp_busy_out && $past(ramp_busy_out) && $changed(current_step_out)
    |-> ramp_steps_left_out == 5'($past(ramp_steps_left_out) - 5'h01)) else $error("count");
  AST_ZERO_OFF: assert property ((current_step_out == 5'h00) [*3] |-> led_on_out == 3'h0)
    else $error("led on at zero step");
  // Main scenarios reached
  cover property ($fell(ramp_busy_out));
  cover property ($rose(sda_oe_out));
  cover property (ramp_busy_out && current_step_out == 5'h00);
endmodule : rgb_dim_ctrl_props
bind rgb_dim_ctrl rgb_dim_ctrl_props i_props (.core_clk_in, .rst_b_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_out, .current_step_out, .ramp_steps_left_out, .ramp_busy_out, .led_on_out);

/* dv/i2c_master_model.sv */
// Bus master model that writes one command per frame
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // One bus timing slot of 12 clocks; clock high lasts one slot, low lasts two
  task automatic half();
    repeat (12) @(negedge clk_in);
  endtask : half
  // START, address, command, STOP; returns both acknowledge bits
  task automatic frame(input logic [7:0] adr, input logic [7:0] c, output logic [1:0] ack);
    logic [15:0] sh;
    sh = {adr, c};
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b0;
    for (int b = 0; b < 18; b++) begin
      half();
      sda_pull_out = (b % 9 == 8) ? 1'b0 : !sh[15];
      if (b % 9 != 8) sh = sh << 1;
      half();
      scl_out = 1'b1;
      half();
      if (b % 9 == 8) ack[1 - b / 9] = !sda_in;
      scl_out = 1'b0;
    end
    half();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b0;
    half();
  endtask : frame
endmodule : i2c_master_model

/* dv/tb_top.sv */
// Self-checking bench for the LED dimming controller
`timescale 1ns/1ps
module tb_top;
  import rgb_dim_pkg::*;
  localparam int SU = 4;
  logic core_clk_in, rst_b_in, scl, pull, sda, sda_out, sda_oe_out, ramp_busy_out;
  logic [4:0] current_step_out, ramp_steps_left_out;
  logic [2:0] led_on_out;
  int n_fail, checks, cyc;
  // Open-drain data line with pull-up
  assign sda = !(pull | (sda_oe_out & !sda_out));
  rgb_dim_ctrl #(.STEP_UNIT_CYCLES_P(SU)) i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .current_step_out(current_step_out),
    .ramp_steps_left_out(ramp_steps_left_out), .ramp_busy_out(ramp_busy_out), .led_on_out(led_on_out));
  i2c_master_model i_mst (.clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c);
    logic [1:0] a;
    i_mst.frame({DEV_ADDR, DIR_WRITE}, c, a);
    chk(a === 2'b11, "no ack");
  endtask : cmd
  task automatic test_done();
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // Reset state, direct peak write, shutdown, foreign address
  task automatic t_peak();
    logic [1:0] a;
    chk(current_step_out === 5'h00 && led_on_out === 3'h0 && sda_oe_out === 1'b0, "reset");
    cmd(8'h2A);
    chk(current_step_out === 5'h0A && ramp_busy_out === 1'b0, "peak");
    cmd(8'h1F);
    chk(current_step_out === 5'h00, "shutdown");
    i_mst.frame(8'h72, 8'h2A, a);
    chk(a === 2'b00 && current_step_out === 5'h00, "foreign");
    i_mst.frame({DEV_ADDR, !DIR_WRITE}, 8'h2A, a);
    chk(a === 2'b00 && current_step_out === 5'h00, "read dir");
  endtask : t_peak
  // Start a ramp of four steps and follow it to the end
  task automatic ramp(input logic [4:0] fin);
    int c, n;
    logic [4:0] s;
    cmd(8'hFF);
    chk(ramp_busy_out === 1'b1 && ramp_steps_left_out === 5'h04, "start");
    c = 0;
    n = 0;
    s = current_step_out;
    while (ramp_busy_out === 1'b1 && c < 3000) begin
      @(negedge core_clk_in);
      c++;
      if (current_step_out !== s) n++;
      s = current_step_out;
    end
    chk(n == 4 && c > 3 * 31 * SU && c <= 4 * 31 * SU + 1, "timing");
    chk(current_step_out === fin, "final");
  endtask : ramp
  // Rising ramp from 30 to 2 wraps through 31 and 0
  task automatic t_rise();
    cmd(8'h3E);
    cmd(8'hA2);
    ramp(5'h02);
  endtask : t_rise
  // Falling ramp from 2 to 30; last written target sets direction
  task automatic t_fall();
    cmd(8'hA5);
    cmd(8'hDE);
    ramp(5'h1E);
  endtask : t_fall
  // Duty full, off and half over one modulator frame
  task automatic t_duty();
    int h0, h1, h2;
    cmd(8'h5F);
    cmd(8'h60);
    cmd(8'h90);
    h0 = 0;
    h1 = 0;
    h2 = 0;
    repeat (31 * PWM_TICK_CYCLES) begin
      @(negedge core_clk_in);
      h0 += int'(led_on_out[0] === 1'b1);
      h1 += int'(led_on_out[1] === 1'b1);
      h2 += int'(led_on_out[2] === 1'b1);
    end
    chk(h0 == 31 * PWM_TICK_CYCLES && h1 == 0, "duty ends");
    chk(h2 == 16 * PWM_TICK_CYCLES && current_step_out === 5'h1E, "duty half");
    cmd(8'h00);
    repeat (3) @(negedge core_clk_in);
    chk(led_on_out === 3'h0, "off");
  endtask : t_duty
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = !core_clk_in;
  end
  // Hang guard
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (3) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    t_peak();
    t_rise();
    t_fall();
    t_duty();
    test_done();
  end
endmodule : tb_top
